// *** shared/timer16_regs.svh ***
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// ----------------------------------------------------------------------------
// Waveform mode field codes handled by this block
// ----------------------------------------------------------------------------
`define WGM_NORMAL 4'h0
`define WGM_CTC_CMP_A 4'h4
`define WGM_CTC_CAPTURE 4'hc

// ----------------------------------------------------------------------------
// Counter limits
// ----------------------------------------------------------------------------
`define COUNT_MAX 16'hffff
`define COUNT_BOTTOM 16'h0000

// ----------------------------------------------------------------------------
// Compare action field codes in the non-PWM modes
// ----------------------------------------------------------------------------
`define ACT_NONE 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OCS_RESET 1'h0
`define FLAG_RESET 1'h0

`endif

// *** shared/timer16_pkg.sv ***
`default_nettype none

package timer16_pkg;

	// ------------------------------------------------------------------------
	// Counting behaviour decoded from the waveform mode field
	// ------------------------------------------------------------------------
	typedef enum logic [3:0] {
		CNT_NORMAL = 4'h1,
		CNT_CTC_CMP_A = 4'h2,
		CNT_CTC_CAPTURE = 4'h4,
		CNT_PWM = 4'h8
	} count_mode_t;

	// ------------------------------------------------------------------------
	// Register state of the counter core
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] count;
		logic [1:0] match_flag;
		logic overflow;
		logic capture;
		logic blocked;
	} core_state_t;

	// ------------------------------------------------------------------------
	// Register state of one output compare channel
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic ocs;
	} chan_state_t;

endpackage

`default_nettype wire

// *** logic/compare_channel.sv ***
`include "timer16_regs.svh"
`default_nettype none

module compare_channel (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic event_i,
	input wire logic [1:0] action_i,
	input wire logic pin_enable_i,
	input wire logic pin_direction_i,
	input wire logic port_value_i,
	output logic state_o,
	output logic pin_o,
	output logic pin_oe_o
);

	timer16_pkg::chan_state_t st_ff;
	timer16_pkg::chan_state_t nxt_st;

	function automatic logic apply_action(input logic cur, input logic [1:0] act);
		case (act)
			`ACT_TOGGLE: apply_action = ~cur;
			`ACT_CLEAR: apply_action = 1'b0;
			`ACT_SET: apply_action = 1'b1;
			default: apply_action = cur;
		endcase
	endfunction

	// The state only moves on an event; a mode change alone never touches it.
	always_comb begin
		nxt_st = st_ff;
		if (event_i) begin
			nxt_st.ocs = apply_action(st_ff.ocs, action_i);
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_ff.ocs <= `OCS_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign state_o = st_ff.ocs;
	// The port value is kept whenever pin_enable_i is low, so software can
	// preset the state before handing the pin over.
	assign pin_o = (pin_enable_i && (action_i != `ACT_NONE)) ? st_ff.ocs : port_value_i;
	assign pin_oe_o = pin_direction_i;

endmodule

`default_nettype wire

// *** logic/timer16_compare_output_normal_ctc.sv ***
`include "timer16_regs.svh"
`default_nettype none

module timer16_compare_output_normal_ctc (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic tick_i,
	input wire logic [3:0] waveform_mode_field_i,
	input wire logic timer_count_wr_i,
	input wire logic [15:0] timer_count_wdata_i,
	input wire logic [15:0] compare_value_a_i,
	input wire logic [15:0] compare_value_b_i,
	input wire logic [15:0] capture_value_i,
	input wire logic capture_event_i,
	input wire logic [1:0] compare_action_field_a_i,
	input wire logic [1:0] compare_action_field_b_i,
	input wire logic force_compare_strobe_a_i,
	input wire logic force_compare_strobe_b_i,
	input wire logic [1:0] pin_output_enable_bit_i,
	input wire logic [1:0] pin_direction_bit_i,
	input wire logic [1:0] port_value_i,
	input wire logic [1:0] match_flag_clr_i,
	input wire logic overflow_flag_clr_i,
	input wire logic capture_flag_clr_i,
	output logic [15:0] timer_count_o,
	output logic [1:0] compare_match_flag_o,
	output logic overflow_flag_o,
	output logic capture_flag_o,
	output logic [1:0] compare_output_state_o,
	output logic [1:0] compare_output_pin_o,
	output logic [1:0] compare_output_pin_oe_o
);

	// ------------------------------------------------------------------------
	// Mode decoding
	// ------------------------------------------------------------------------
	function automatic timer16_pkg::count_mode_t decode_mode(input logic [3:0] wgm);
		case (wgm)
			`WGM_NORMAL: decode_mode = timer16_pkg::CNT_NORMAL;
			`WGM_CTC_CMP_A: decode_mode = timer16_pkg::CNT_CTC_CMP_A;
			`WGM_CTC_CAPTURE: decode_mode = timer16_pkg::CNT_CTC_CAPTURE;
			default: decode_mode = timer16_pkg::CNT_PWM;
		endcase
	endfunction

	function automatic logic is_non_pwm(input logic [3:0] wgm);
		is_non_pwm = (decode_mode(wgm) != timer16_pkg::CNT_PWM);
	endfunction

	timer16_pkg::core_state_t st_ff;
	timer16_pkg::core_state_t nxt_st;
	timer16_pkg::count_mode_t mode;
	logic non_pwm;
	logic live_tick;
	logic [1:0] cmp_match;
	logic [1:0] wave_event;
	logic [1:0] force_strobe;
	logic [1:0] action [2];
	logic [15:0] top_value;
	logic top_match;

	assign mode = decode_mode(waveform_mode_field_i);
	assign non_pwm = is_non_pwm(waveform_mode_field_i);
	assign force_strobe = {force_compare_strobe_b_i, force_compare_strobe_a_i};
	assign action[0] = compare_action_field_a_i;
	assign action[1] = compare_action_field_b_i;
	// The first tick after a counter write, however many cycles later, counts but must not match.
	assign live_tick = tick_i && !st_ff.blocked;
	assign cmp_match[0] = live_tick && (st_ff.count == compare_value_a_i);
	assign cmp_match[1] = live_tick && (st_ff.count == compare_value_b_i);
	// TOP is read straight from the register, so a value written below the
	// current count is only met again after the counter wraps.
	assign top_value = (mode == timer16_pkg::CNT_CTC_CAPTURE) ? capture_value_i : compare_value_a_i;
	assign top_match = live_tick && (st_ff.count == top_value);

	// ------------------------------------------------------------------------
	// Counter core
	// ------------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		for (int i = 0; i < 2; i++) begin
			if (match_flag_clr_i[i]) begin
				nxt_st.match_flag[i] = 1'b0;
			end
			if (cmp_match[i]) begin
				nxt_st.match_flag[i] = 1'b1;
			end
		end
		if (overflow_flag_clr_i) begin
			nxt_st.overflow = 1'b0;
		end
		if (capture_flag_clr_i) begin
			nxt_st.capture = 1'b0;
		end
		if (capture_event_i) begin
			nxt_st.capture = 1'b1;
		end
		if (tick_i) begin
			nxt_st.blocked = 1'b0;
			if (st_ff.count == `COUNT_MAX) begin
				nxt_st.overflow = 1'b1;
			end
			case (mode)
				timer16_pkg::CNT_CTC_CMP_A: begin
					nxt_st.count = top_match ? `COUNT_BOTTOM : st_ff.count + 16'h0001;
				end
				timer16_pkg::CNT_CTC_CAPTURE: begin
					nxt_st.count = top_match ? `COUNT_BOTTOM : st_ff.count + 16'h0001;
					if (top_match) begin
						nxt_st.capture = 1'b1;
					end
				end
				default: begin
					nxt_st.count = st_ff.count + 16'h0001;
				end
			endcase
		end
		// A processor write lands on the system clock and wins over the tick.
		if (timer_count_wr_i) begin
			nxt_st.count = timer_count_wdata_i;
			nxt_st.blocked = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_ff.count <= `COUNT_BOTTOM;
			st_ff.match_flag <= {2{`FLAG_RESET}};
			st_ff.overflow <= `FLAG_RESET;
			st_ff.capture <= `FLAG_RESET;
			st_ff.blocked <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign timer_count_o = st_ff.count;
	assign compare_match_flag_o = st_ff.match_flag;
	assign overflow_flag_o = st_ff.overflow;
	assign capture_flag_o = st_ff.capture;

	// ------------------------------------------------------------------------
	// Output compare channels
	// ------------------------------------------------------------------------
	// PWM waveform shaping lives elsewhere; here the state only follows
	// matches and forces in the non-PWM modes and otherwise holds.
	for (genvar g = 0; g < 2; g++) begin : gen_chan
		assign wave_event[g] = non_pwm && (cmp_match[g] || force_strobe[g]);
		compare_channel u_chan (
			.mclk_i(mclk_i),
			.arst_n_i(arst_n_i),
			.event_i(wave_event[g]),
			.action_i(action[g]),
			.pin_enable_i(pin_output_enable_bit_i[g]),
			.pin_direction_i(pin_direction_bit_i[g]),
			.port_value_i(port_value_i[g]),
			.state_o(compare_output_state_o[g]),
			.pin_o(compare_output_pin_o[g]),
			.pin_oe_o(compare_output_pin_oe_o[g])
		);
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);

	property p_force_toggles;
		(non_pwm && force_compare_strobe_a_i && compare_action_field_a_i == `ACT_TOGGLE)
			|=> compare_output_state_o[0] == !$past(compare_output_state_o[0]);
	endproperty
	a_force_toggles: assert property (p_force_toggles) else $error("force did not toggle output A");

	property p_force_no_side_effect;
		(force_compare_strobe_b_i && !tick_i && !timer_count_wr_i && !match_flag_clr_i[1])
			|=> $stable(timer_count_o) && $stable(compare_match_flag_o[1]);
	endproperty
	a_force_no_side_effect: assert property (p_force_no_side_effect) else $error("force touched count or flag");

	property p_write_blocks;
		(timer_count_wr_i && timer_count_wdata_i == compare_value_a_i && !compare_match_flag_o[0])
			##1 (!timer_count_wr_i && tick_i && !match_flag_clr_i[0] && $stable(compare_value_a_i))
			|=> !compare_match_flag_o[0];
	endproperty
	a_write_blocks: assert property (p_write_blocks) else $error("match after counter write not blocked");

	property p_action_zero_holds;
		(compare_action_field_b_i == `ACT_NONE) |=> $stable(compare_output_state_o[1]);
	endproperty
	a_action_zero_holds: assert property (p_action_zero_holds) else $error("action zero changed output B");

	property p_pin_mux;
		compare_output_pin_o[0] == ((pin_output_enable_bit_i[0] && compare_action_field_a_i != `ACT_NONE)
			? compare_output_state_o[0] : port_value_i[0]);
	endproperty
	a_pin_mux: assert property (p_pin_mux) else $error("pin A override wrong");

	property p_pin_dir;
		compare_output_pin_oe_o == pin_direction_bit_i;
	endproperty
	a_pin_dir: assert property (p_pin_dir) else $error("pin direction not from direction bit");

	property p_normal_wrap;
		(mode == timer16_pkg::CNT_NORMAL && tick_i && !timer_count_wr_i && timer_count_o == `COUNT_MAX)
			|=> timer_count_o == `COUNT_BOTTOM && overflow_flag_o;
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow wrong");

	property p_normal_inc;
		(mode == timer16_pkg::CNT_NORMAL && tick_i && !timer_count_wr_i)
			|=> timer_count_o == $past(timer_count_o) + 16'h0001;
	endproperty
	a_normal_inc: assert property (p_normal_inc) else $error("normal mode did not increment");

	property p_ctc_a_clear;
		(mode == timer16_pkg::CNT_CTC_CMP_A && tick_i && !st_ff.blocked && !timer_count_wr_i
			&& timer_count_o == compare_value_a_i)
			|=> timer_count_o == `COUNT_BOTTOM && compare_match_flag_o[0];
	endproperty
	a_ctc_a_clear: assert property (p_ctc_a_clear) else $error("CTC A did not clear at TOP");

	property p_ctc_cap_clear;
		(mode == timer16_pkg::CNT_CTC_CAPTURE && tick_i && !st_ff.blocked && !timer_count_wr_i
			&& timer_count_o == capture_value_i)
			|=> timer_count_o == `COUNT_BOTTOM && capture_flag_o;
	endproperty
	a_ctc_cap_clear: assert property (p_ctc_cap_clear) else $error("CTC capture TOP not honoured");

	property p_ctc_no_overflow;
		(mode == timer16_pkg::CNT_CTC_CMP_A && tick_i && !overflow_flag_o && !timer_count_wr_i
			&& timer_count_o != `COUNT_MAX)
			|=> !overflow_flag_o;
	endproperty
	a_ctc_no_overflow: assert property (p_ctc_no_overflow) else $error("CTC overflow away from MAX");

	property p_ctc_wrap_past_top;
		(mode == timer16_pkg::CNT_CTC_CMP_A && tick_i && !timer_count_wr_i
			&& timer_count_o == `COUNT_MAX && compare_value_a_i != `COUNT_MAX)
			|=> timer_count_o == `COUNT_BOTTOM && overflow_flag_o;
	endproperty
	a_ctc_wrap_past_top: assert property (p_ctc_wrap_past_top) else $error("CTC did not wrap past TOP");

	property p_ctc_toggle;
		(mode == timer16_pkg::CNT_CTC_CMP_A && compare_action_field_a_i == `ACT_TOGGLE
			&& tick_i && !st_ff.blocked && timer_count_o == compare_value_a_i && !force_compare_strobe_a_i)
			|=> compare_output_state_o[0] != $past(compare_output_state_o[0]);
	endproperty
	a_ctc_toggle: assert property (p_ctc_toggle) else $error("CTC toggle missed");

	property p_flag_set_wins;
		(tick_i && !st_ff.blocked && timer_count_o == compare_value_b_i && match_flag_clr_i[1])
			|=> compare_match_flag_o[1];
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag set lost to clear");

	property p_flag_clear;
		(match_flag_clr_i[1] && !cmp_match[1]) |=> !compare_match_flag_o[1];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag B not cleared");

	property p_no_tick_holds;
		(!tick_i && !timer_count_wr_i) |=> $stable(timer_count_o);
	endproperty
	a_no_tick_holds: assert property (p_no_tick_holds) else $error("count moved without tick");

	property p_pwm_holds;
		(mode == timer16_pkg::CNT_PWM && $stable(waveform_mode_field_i)) |=> $stable(compare_output_state_o);
	endproperty
	a_pwm_holds: assert property (p_pwm_holds) else $error("output state moved in PWM mode");

	c_ctc_a_top: cover property (mode == timer16_pkg::CNT_CTC_CMP_A && top_match);
	c_force: cover property (non_pwm && force_compare_strobe_b_i ##1 compare_output_state_o[1]);
	c_blocked: cover property (timer_count_wr_i ##1 tick_i && st_ff.count == compare_value_a_i);
	c_normal_ovf: cover property ($rose(overflow_flag_o));

endmodule

`default_nettype wire

// *** sim/port_pin_model.sv ***
`default_nettype none

// ----------------------------------------------------------------------------
// Port pad with pull-up
// ----------------------------------------------------------------------------
module port_pin_model (
	input wire logic [1:0] pin_i,
	input wire logic [1:0] oe_i,
	output logic [1:0] pad_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// A released pad reads the pull-up level, so a driver that stops driving
	// cannot pass because the last driven value was remembered.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pad_o[i] = oe_i[i] ? pin_i[i] : 1'b1;
		end
	end
endmodule

`default_nettype wire

// *** sim/timer16_compare_output_normal_ctc_test.sv ***
`include "timer16_regs.svh"
`default_nettype none

module timer16_compare_output_normal_ctc_test;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [1:0] act;
		logic en;
		logic port;
		logic st;
		logic pin;
	} row_t;

	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic tick = 1'b0, wr = 1'b0, cap_ev = 1'b0, frc_a = 1'b0, oclr = 1'b0, cclr = 1'b0;
	logic [3:0] mode = `WGM_NORMAL;
	logic [15:0] wdata = 16'h0000, cmp_a = 16'hffff, cmp_b = 16'hffff, cap = 16'hffff;
	logic [1:0] act_a = 2'h0, act_b = 2'h0, en = 2'h0, dir = 2'h3, port = 2'h0, mclr = 2'h0;
	logic [15:0] count;
	logic [1:0] mflag, st, pin, oe;
	logic ovf, cflag;
	wire logic [1:0] pad;
	int err_count = 0;
	int cmp_count = 0;
	row_t rows [7] = '{'{2'h3, 1'b1, 1'b0, 1'b1, 1'b1}, '{2'h0, 1'b1, 1'b0, 1'b1, 1'b0},
		'{2'h2, 1'b1, 1'b1, 1'b0, 1'b0}, '{2'h1, 1'b1, 1'b1, 1'b1, 1'b1}, '{2'h1, 1'b0, 1'b0, 1'b0, 1'b0},
		'{2'h3, 1'b0, 1'b0, 1'b1, 1'b0}, '{2'h3, 1'b1, 1'b0, 1'b1, 1'b1}};

	always #2 mclk_i = ~mclk_i;

	// Both force strobes share one driver, so every force also exercises channel B.
	timer16_compare_output_normal_ctc dut (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .tick_i(tick), .waveform_mode_field_i(mode),
		.timer_count_wr_i(wr), .timer_count_wdata_i(wdata), .compare_value_a_i(cmp_a),
		.compare_value_b_i(cmp_b), .capture_value_i(cap), .capture_event_i(cap_ev),
		.compare_action_field_a_i(act_a), .compare_action_field_b_i(act_b),
		.force_compare_strobe_a_i(frc_a), .force_compare_strobe_b_i(frc_a),
		.pin_output_enable_bit_i(en), .pin_direction_bit_i(dir), .port_value_i(port),
		.match_flag_clr_i(mclr), .overflow_flag_clr_i(oclr), .capture_flag_clr_i(cclr),
		.timer_count_o(count), .compare_match_flag_o(mflag), .overflow_flag_o(ovf),
		.capture_flag_o(cflag), .compare_output_state_o(st), .compare_output_pin_o(pin),
		.compare_output_pin_oe_o(oe)
	);

	port_pin_model pads (.pin_i(pin), .oe_i(oe), .pad_o(pad));

	// ------------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		if (err_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic ticks(input int n);
		tick = 1'b1;
		repeat (n) @(negedge mclk_i);
		tick = 1'b0;
	endtask

	// Counter values written here are never a variable TOP of a PWM mode.
	task automatic wr_count(input logic [15:0] v);
		wr = 1'b1;
		wdata = v;
		@(negedge mclk_i);
		wr = 1'b0;
	endtask

	task automatic force_a;
		frc_a = 1'b1;
		@(negedge mclk_i);
		frc_a = 1'b0;
	endtask

	initial begin
		#20000;
		err_count++;
		end_of_test();
	end

	initial begin
		repeat (3) @(negedge mclk_i);
		arst_n_i = 1'b1;
		@(negedge mclk_i);
		foreach (rows[i]) begin
			act_a = rows[i].act;
			en[0] = rows[i].en;
			port[0] = rows[i].port;
			force_a();
			check(st[0], rows[i].st);
			check(pin[0], rows[i].pin);
			check(pad[0], rows[i].pin);
			check(mflag, 2'h0);
			check(count, 16'h0000);
		end
		// --------------------------------------------------------------------
		// Reset and pin direction
		// --------------------------------------------------------------------
		wr_count(16'h1234);
		arst_n_i = 1'b0;
		@(negedge mclk_i);
		check(st, 2'h0);
		check(count, 16'h0000);
		repeat (2) @(negedge mclk_i);
		arst_n_i = 1'b1;
		dir = 2'h0;
		@(negedge mclk_i);
		check(oe, 2'h0);
		check(pad[0], 1'b1);
		dir = 2'h3;
		// --------------------------------------------------------------------
		// Match blocking after a counter write
		// --------------------------------------------------------------------
		cmp_a = 16'h0005;
		wr_count(16'h0005);
		ticks(1);
		check(count, 16'h0006);
		check(mflag[0], 1'b0);
		cmp_a = 16'h0006;
		ticks(1);
		check(count, 16'h0007);
		check(mflag[0], 1'b1);
		mclr = 2'h1;
		@(negedge mclk_i);
		mclr = 2'h0;
		check(mflag[0], 1'b0);
		cmp_a = 16'h0007;
		wr_count(16'h0007);
		repeat (5) @(negedge mclk_i);
		ticks(1);
		check(mflag[0], 1'b0);
		check(count, 16'h0008);
		// --------------------------------------------------------------------
		// Normal mode wrap
		// --------------------------------------------------------------------
		wr_count(16'hfffe);
		ticks(1);
		check(count, 16'hffff);
		check(ovf, 1'b0);
		ticks(1);
		check(count, 16'h0000);
		check(ovf, 1'b1);
		oclr = 1'b1;
		// --------------------------------------------------------------------
		// State held across mode changes; no forcing in PWM modes
		// --------------------------------------------------------------------
		act_a = `ACT_SET;
		force_a();
		oclr = 1'b0;
		mode = 4'h5;
		repeat (2) @(negedge mclk_i);
		act_a = `ACT_CLEAR;
		force_a();
		check(st[0], 1'b1);
		check(ovf, 1'b0);
		// --------------------------------------------------------------------
		// Clear on match, TOP from compare A
		// --------------------------------------------------------------------
		mode = `WGM_CTC_CMP_A;
		cmp_a = 16'h0003;
		mclr = 2'h3;
		force_a();
		mclr = 2'h0;
		check(st[0], 1'b0);
		act_a = `ACT_TOGGLE;
		en = 2'h3;
		port = 2'h0;
		wr_count(16'h0000);
		ticks(3);
		check(count, 16'h0003);
		check(st[0], 1'b0);
		ticks(1);
		check(count, 16'h0000);
		check(st[0], 1'b1);
		check(pad[0], 1'b1);
		check(mflag[0], 1'b1);
		// Half a toggle period is 1 + compare A ticks at a prescale of one.
		ticks(4);
		check(st[0], 1'b0);
		act_a = `ACT_CLEAR;
		ticks(4);
		check(st[0], 1'b0);
		check(count, 16'h0000);
		check(ovf, 1'b0);
		wr_count(16'hfffe);
		ticks(1);
		check(count, 16'hffff);
		ticks(1);
		check(count, 16'h0000);
		check(ovf, 1'b1);
		// --------------------------------------------------------------------
		// Clear on match, TOP from the capture register
		// --------------------------------------------------------------------
		mode = `WGM_CTC_CAPTURE;
		cap = 16'h0002;
		mclr = 2'h3;
		wr_count(16'h0000);
		mclr = 2'h0;
		ticks(2);
		check(count, 16'h0002);
		ticks(1);
		check(count, 16'h0000);
		check(cflag, 1'b1);
		check(mflag[0], 1'b0);
		cclr = 1'b1;
		@(negedge mclk_i);
		cclr = 1'b0;
		check(cflag, 1'b0);
		cap_ev = 1'b1;
		@(negedge mclk_i);
		cap_ev = 1'b0;
		check(cflag, 1'b1);
		// --------------------------------------------------------------------
		// Channel B: forced set, then a match against a flag clear
		// --------------------------------------------------------------------
		act_b = `ACT_SET;
		force_a();
		check(st[1], 1'b1);
		check(mflag[1], 1'b0);
		check(pad[1], 1'b1);
		cmp_b = 16'h0000;
		mclr = 2'h2;
		ticks(1);
		mclr = 2'h0;
		check(mflag[1], 1'b1);
		check(count, 16'h0001);
		end_of_test();
	end
endmodule

`default_nettype wire
